// >>> logic/lcd_cfg_pkg.sv
// Register map, field positions and timing constants of the segment LCD control
package lcd_cfg_pkg;
   // Register offsets
   localparam logic [7:0] OFF_MAIN_CONFIG = 8'h95;
   localparam logic [7:0] OFF_CLOCK_CONFIG = 8'h96;
   localparam logic [7:0] OFF_PIN_SELECT_LOW = 8'h97;
   localparam logic [7:0] OFF_VOLTAGE_CONFIG = 8'h9C;
   localparam logic [7:0] OFF_MEMORY_INDEX = 8'hAC;
   localparam logic [7:0] OFF_MEMORY_PORT = 8'hAE;
   localparam logic [7:0] OFF_FRAME_CONTROL = 8'hB1;
   localparam logic [7:0] OFF_PIN_SELECT_HIGH = 8'hED;
   // Main configuration fields
   localparam int BIT_DRIVER_ON = 7;
   localparam int BIT_SEGMENT_MEMORY_CLEAR = 6;
   localparam int BIT_BLINK_ON = 5;
   localparam int BIT_SLEEP_DISPLAY_OFF = 4;
   localparam int BIT_FRAME_CLOCK_SELECT = 3;
   localparam int BIT_BIAS_SELECT = 2;
   localparam int POS_MULTIPLEX_SELECT = 0;
   // Clock configuration fields
   localparam int POS_BLINK_SOURCE_MODE = 6;
   localparam int POS_BLINK_RATE_SELECT = 4;
   localparam int POS_FRAME_DIVIDER = 0;
   // Frame control fields
   localparam int BIT_FRAME_INVERT = 6;
   localparam int BIT_FRAME_UPDATE_DONE = 1;
   localparam int BIT_REFRESH_HOLD = 0;
   // Writable mask of frame control; bit 1 is set by hardware only
   localparam logic [7:0] FRAME_CONTROL_WMASK = 8'h41;
   localparam logic [7:0] VOLTAGE_CONFIG_WMASK = 8'h7F;
   // Reset values
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int FAST_FRAME_HZ = 2048;
   localparam int SLOW_FRAME_HZ = 128;
   localparam int FAST_TICK_CYCLES = CLK_HZ / FAST_FRAME_HZ;
   localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_FRAME_HZ;
   localparam int SEGMENT_BYTES = 18;

   typedef enum logic [1:0] {
      MUX_RESERVED = 2'b00,
      MUX_TWO = 2'b01,
      MUX_THREE = 2'b10,
      MUX_FOUR = 2'b11
   } mux_type;

   typedef enum logic [1:0] {
      SHARED_OFF = 2'b00,
      SHARED_SEGMENT = 2'b01,
      SHARED_BACKPLANE = 2'b10
   } pin_role_type;

   // Roles of the two shared pins
   typedef struct packed {
      pin_role_type pin_a;
      pin_role_type pin_b;
   } shared_role_type;

   // Byte-wide special-function register access
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_type;

   // Frame engine settings
   typedef struct packed {
      logic active;
      logic slow_clock;
      logic bias_third;
      logic [1:0] mux;
      logic [3:0] divider;
      logic invert;
   } frame_cfg_type;
endpackage

// >>> logic/lcd_frame_timer.sv
// Frame tick generator: base clock from the selected rate, then divided
`timescale 1ns/1ps
module lcd_frame_timer #(
   parameter int FAST_CYCLES = lcd_cfg_pkg::FAST_TICK_CYCLES,
   parameter int SLOW_CYCLES = lcd_cfg_pkg::SLOW_TICK_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Settings
   input wire logic run,
   input wire logic slow_clock,
   input wire logic [3:0] divider,
   // Frame start pulse
   output logic frame_tick
);
   import lcd_cfg_pkg::*;

   initial begin
      if (FAST_CYCLES < 1 || SLOW_CYCLES < FAST_CYCLES) begin
         $error("lcd_frame_timer: bad cycle counts");
      end
   end

   logic [31:0] base_cnt_r;
   logic [4:0] div_cnt_r;
   logic base_tick;

   assign base_tick = slow_clock ? (base_cnt_r >= 32'(SLOW_CYCLES - 1))
                                 : (base_cnt_r >= 32'(FAST_CYCLES - 1));

   always_ff @(posedge mclk) begin
      if (reset || !run || base_tick) begin
         base_cnt_r <= 32'h0;
      end else begin
         base_cnt_r <= base_cnt_r + 32'h1;
      end
   end

   // A frame spans divider+1 base periods
   always_ff @(posedge mclk) begin
      if (reset || !run) begin
         div_cnt_r <= 5'h0;
         frame_tick <= 1'b0;
      end else if (base_tick && div_cnt_r >= {1'b0, divider}) begin
         div_cnt_r <= 5'h0;
         frame_tick <= 1'b1;
      end else begin
         if (base_tick) begin
            div_cnt_r <= div_cnt_r + 5'h1;
         end
         frame_tick <= 1'b0;
      end
   end
endmodule // lcd_frame_timer

// >>> logic/lcd_segment_driver_config.sv
// Segment LCD driver configuration, data memory and frame control
//
// Operation
// (R1) Enable bit activates waveform generation
// (R2) Clear bit zeroes all segment data
// (R3) Blink bit enables blink per clock register
// (R4) Sleep-off clear: sleep follows enable bit
// (R5) Sleep-off set: driver off in sleep
// (R6) Software enables voltage reference before sleep
// (R7) Clock select: 0 fast, 1 slow rate
// (R8) Mux 01: two-way, pins are segments
// (R9) Mux 10: pin a segment, b backplane
// (R10) Mux 11: pin a, b both backplanes
// (R11) Module operates in every power mode
// (R12) Drives panel up to 17 by 4
// (R13) Pin select registers route shared pins
// (R14) Clock register holds frame, blink timing
// (R15) Refresh hold freezes display, resumes next frame
// (R16) Done flag set when new frame loaded
// (R17) Bias bit: half or third bias
// (R18) Data reached through index and port
`timescale 1ns/1ps
module lcd_segment_driver_config
   import lcd_cfg_pkg::*;
#(
   parameter int MEM_BYTES = lcd_cfg_pkg::SEGMENT_BYTES,
   parameter int FAST_CYCLES = lcd_cfg_pkg::FAST_TICK_CYCLES,
   parameter int SLOW_CYCLES = lcd_cfg_pkg::SLOW_TICK_CYCLES
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Register port
   input wire lcd_cfg_pkg::sfr_req_type sfr_req,
   output logic [7:0] sfr_rdata,
   // Power state
   input wire logic deep_sleep_state,
   // Frame engine view
   output lcd_cfg_pkg::frame_cfg_type frame_cfg,
   output logic frame_start,
   output logic blink_on,
   output logic [1:0] blink_source_mode,
   output logic [1:0] blink_rate_select,
   output logic [7:0] lcd_voltage_config,
   output lcd_cfg_pkg::shared_role_type shared_role,
   output logic [15:0] pin_select,
   // Displayed segment data
   output logic [8*lcd_cfg_pkg::SEGMENT_BYTES-1:0] display_data
);
   initial begin
      if (MEM_BYTES < 1 || MEM_BYTES > SEGMENT_BYTES) begin
         $error("lcd_segment_driver_config: MEM_BYTES out of range");
      end
   end

   logic [7:0] lcd_main_config_r;
   logic [7:0] lcd_clock_config_r;
   logic [7:0] lcd_pin_select_low_r;
   logic [7:0] lcd_voltage_config_r;
   logic [7:0] lcd_memory_index_r;
   logic [7:0] lcd_frame_control_r;
   logic [7:0] lcd_pin_select_high_r;
   logic [7:0] seg_mem_r [SEGMENT_BYTES];
   logic sleep_r;
   logic sleep_sync_r;
   logic driver_active;
   logic tick;
   logic frame_active_r;

   function automatic logic hit(input sfr_req_type r, input logic [7:0] off);
      hit = r.addr == off;
   endfunction

   // Power state comes from another domain
   always_ff @(posedge mclk) begin
      if (reset) begin
         sleep_sync_r <= 1'b0;
         sleep_r <= 1'b0;
      end else begin
         sleep_sync_r <= deep_sleep_state;
         sleep_r <= sleep_sync_r;
      end
   end

   // Clear bit is a command; hardware drops it once memory is zeroed
   always_ff @(posedge mclk) begin
      if (reset) begin
         lcd_main_config_r <= RESET_VALUE;
      end else if (sfr_req.wr && hit(sfr_req, OFF_MAIN_CONFIG)) begin
         lcd_main_config_r <= sfr_req.wdata;
      end else begin
         lcd_main_config_r[BIT_SEGMENT_MEMORY_CLEAR] <= 1'b0; // see (R2)
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         lcd_clock_config_r <= RESET_VALUE;
         lcd_pin_select_low_r <= RESET_VALUE;
         lcd_pin_select_high_r <= RESET_VALUE;
         lcd_voltage_config_r <= RESET_VALUE;
      end else if (sfr_req.wr) begin
         if (hit(sfr_req, OFF_CLOCK_CONFIG)) begin
            lcd_clock_config_r <= sfr_req.wdata; // see (R14)
         end else if (hit(sfr_req, OFF_PIN_SELECT_LOW)) begin
            lcd_pin_select_low_r <= sfr_req.wdata; // see (R13)
         end else if (hit(sfr_req, OFF_PIN_SELECT_HIGH)) begin
            lcd_pin_select_high_r <= sfr_req.wdata; // see (R13)
         end else if (hit(sfr_req, OFF_VOLTAGE_CONFIG)) begin
            lcd_voltage_config_r <= sfr_req.wdata & VOLTAGE_CONFIG_WMASK;
         end
      end
   end

   // Index register wraps nothing: out-of-range indices read zero
   always_ff @(posedge mclk) begin
      if (reset) begin
         lcd_memory_index_r <= RESET_VALUE;
      end else if (sfr_req.wr && hit(sfr_req, OFF_MEMORY_INDEX)) begin
         lcd_memory_index_r <= sfr_req.wdata; // see (R18)
      end
   end

   // Segment memory: clear overrides a write in the same cycle
   always_ff @(posedge mclk) begin
      if (reset || lcd_main_config_r[BIT_SEGMENT_MEMORY_CLEAR]) begin
         for (int i = 0; i < SEGMENT_BYTES; i++) begin
            seg_mem_r[i] <= 8'h00; // see (R2)
         end
      end else if (sfr_req.wr && hit(sfr_req, OFF_MEMORY_PORT)
                   && lcd_memory_index_r < 8'(MEM_BYTES)) begin
         seg_mem_r[lcd_memory_index_r[4:0]] <= sfr_req.wdata; // see (R18)
      end
   end

   // Frame control: done flag set by hardware wins over a clearing write
   always_ff @(posedge mclk) begin
      if (reset) begin
         lcd_frame_control_r <= RESET_VALUE;
      end else begin
         if (sfr_req.wr && hit(sfr_req, OFF_FRAME_CONTROL)) begin
            lcd_frame_control_r <= (sfr_req.wdata & FRAME_CONTROL_WMASK)
               | (lcd_frame_control_r & ~FRAME_CONTROL_WMASK
                  & {8{sfr_req.wdata[BIT_FRAME_UPDATE_DONE]}});
         end
         if (tick && !lcd_frame_control_r[BIT_REFRESH_HOLD]) begin
            lcd_frame_control_r[BIT_FRAME_UPDATE_DONE] <= 1'b1; // see (R16)
         end
      end
   end

   // Sleep gating; awake the enable bit alone decides
   assign driver_active = lcd_main_config_r[BIT_DRIVER_ON] // see (R1)
      && !(sleep_r && lcd_main_config_r[BIT_SLEEP_DISPLAY_OFF]); // see (R4) (R5) (R11)

   lcd_frame_timer #(
      .FAST_CYCLES(FAST_CYCLES),
      .SLOW_CYCLES(SLOW_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .reset(reset),
      .run(driver_active),
      .slow_clock(lcd_main_config_r[BIT_FRAME_CLOCK_SELECT]), // see (R7)
      .divider(lcd_clock_config_r[POS_FRAME_DIVIDER +: 4]),
      .frame_tick(tick)
   );

   // Display copy updated only at frame start and only when not held
   always_ff @(posedge mclk) begin
      if (reset) begin
         display_data <= '0;
      end else if (tick && !lcd_frame_control_r[BIT_REFRESH_HOLD]) begin
         for (int i = 0; i < SEGMENT_BYTES; i++) begin
            display_data[8*i +: 8] <= seg_mem_r[i]; // see (R15) (R12)
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         frame_start <= 1'b0;
         frame_active_r <= 1'b0;
      end else begin
         frame_start <= tick;
         frame_active_r <= driver_active;
      end
   end

   // Settings handed to the waveform stage
   always_ff @(posedge mclk) begin
      if (reset) begin
         frame_cfg <= '0;
         blink_on <= 1'b0;
         blink_source_mode <= 2'b00;
         blink_rate_select <= 2'b00;
         lcd_voltage_config <= RESET_VALUE;
         pin_select <= 16'h0000;
      end else begin
         frame_cfg.active <= driver_active; // see (R1)
         frame_cfg.slow_clock <= lcd_main_config_r[BIT_FRAME_CLOCK_SELECT];
         frame_cfg.bias_third <= lcd_main_config_r[BIT_BIAS_SELECT]; // see (R17)
         frame_cfg.mux <= lcd_main_config_r[POS_MULTIPLEX_SELECT +: 2];
         frame_cfg.divider <= lcd_clock_config_r[POS_FRAME_DIVIDER +: 4];
         frame_cfg.invert <= lcd_frame_control_r[BIT_FRAME_INVERT];
         blink_on <= lcd_main_config_r[BIT_BLINK_ON]; // see (R3)
         blink_source_mode <= lcd_clock_config_r[POS_BLINK_SOURCE_MODE +: 2];
         blink_rate_select <= lcd_clock_config_r[POS_BLINK_RATE_SELECT +: 2];
         lcd_voltage_config <= lcd_voltage_config_r;
         pin_select <= {lcd_pin_select_high_r, lcd_pin_select_low_r}; // see (R13)
      end
   end

   // Shared pin roles follow the multiplex level; reserved code leaves both off
   always_ff @(posedge mclk) begin
      if (reset) begin
         shared_role <= '{SHARED_OFF, SHARED_OFF};
      end else begin
         case (mux_type'(lcd_main_config_r[POS_MULTIPLEX_SELECT +: 2]))
            MUX_TWO: begin
               shared_role <= '{SHARED_SEGMENT, SHARED_SEGMENT}; // see (R8)
            end
            MUX_THREE: begin
               shared_role <= '{SHARED_SEGMENT, SHARED_BACKPLANE}; // see (R9)
            end
            MUX_FOUR: begin
               shared_role <= '{SHARED_BACKPLANE, SHARED_BACKPLANE}; // see (R10)
            end
            default: begin
               shared_role <= '{SHARED_OFF, SHARED_OFF}; // see (R8)
            end
         endcase
      end
   end

   // Read data registered one cycle after the read strobe
   always_ff @(posedge mclk) begin
      if (reset) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.rd) begin
         if (hit(sfr_req, OFF_MAIN_CONFIG)) begin
            sfr_rdata <= lcd_main_config_r;
         end else if (hit(sfr_req, OFF_CLOCK_CONFIG)) begin
            sfr_rdata <= lcd_clock_config_r;
         end else if (hit(sfr_req, OFF_PIN_SELECT_LOW)) begin
            sfr_rdata <= lcd_pin_select_low_r;
         end else if (hit(sfr_req, OFF_VOLTAGE_CONFIG)) begin
            sfr_rdata <= lcd_voltage_config_r;
         end else if (hit(sfr_req, OFF_MEMORY_INDEX)) begin
            sfr_rdata <= lcd_memory_index_r;
         end else if (hit(sfr_req, OFF_MEMORY_PORT)) begin
            sfr_rdata <= (lcd_memory_index_r < 8'(MEM_BYTES))
               ? seg_mem_r[lcd_memory_index_r[4:0]] : 8'h00; // see (R18)
         end else if (hit(sfr_req, OFF_FRAME_CONTROL)) begin
            sfr_rdata <= lcd_frame_control_r;
         end else if (hit(sfr_req, OFF_PIN_SELECT_HIGH)) begin
            sfr_rdata <= lcd_pin_select_high_r;
         end else begin
            sfr_rdata <= 8'h00;
         end
      end
   end

   // Assertions
   sequence s_frame_loaded;
      tick && !lcd_frame_control_r[BIT_REFRESH_HOLD];
   endsequence

   a_done_flag_set: assert property (@(posedge mclk) disable iff (reset) // see (R16)
      s_frame_loaded |=> lcd_frame_control_r[BIT_FRAME_UPDATE_DONE])
      else $error("done flag not set after frame load");

   a_clear_zeroes: assert property (@(posedge mclk) disable iff (reset) // see (R2)
      lcd_main_config_r[BIT_SEGMENT_MEMORY_CLEAR] |=> seg_mem_r[0] == 8'h00
         && !lcd_main_config_r[BIT_SEGMENT_MEMORY_CLEAR])
      else $error("segment clear did not take");

   a_sleep_off: assert property (@(posedge mclk) disable iff (reset) // see (R5)
      sleep_r && lcd_main_config_r[BIT_SLEEP_DISPLAY_OFF] |=> !frame_cfg.active)
      else $error("driver active in sleep with display off");

   a_enable_follow: assert property (@(posedge mclk) disable iff (reset) // see (R1) (R4)
      !sleep_r ##1 !$past(sleep_r) |-> frame_cfg.active
         == $past(lcd_main_config_r[BIT_DRIVER_ON]))
      else $error("active does not follow enable");

   a_hold_freezes: assert property (@(posedge mclk) disable iff (reset) // see (R15)
      lcd_frame_control_r[BIT_REFRESH_HOLD] |=> $stable(display_data))
      else $error("display changed during hold");

   a_no_tick_off: assert property (@(posedge mclk) disable iff (reset) // see (R1)
      !frame_active_r ##1 !driver_active |-> !tick)
      else $error("frame while driver inactive");

   a_mux_four: assert property (@(posedge mclk) disable iff (reset) // see (R10)
      lcd_main_config_r[1:0] == 2'b11 ##1 lcd_main_config_r[1:0] == 2'b11
         |-> shared_role.pin_a == SHARED_BACKPLANE)
      else $error("pin a not backplane in four-way mode");

   a_mux_three: assert property (@(posedge mclk) disable iff (reset) // see (R9)
      lcd_main_config_r[1:0] == 2'b10 |=> shared_role.pin_b == SHARED_BACKPLANE
         && shared_role.pin_a == SHARED_SEGMENT)
      else $error("wrong roles in three-way mode");

   a_bias_follow: assert property (@(posedge mclk) disable iff (reset) // see (R17)
      1'b1 |=> frame_cfg.bias_third == $past(lcd_main_config_r[BIT_BIAS_SELECT]))
      else $error("bias output does not follow register");
endmodule // lcd_segment_driver_config

// >>> tb/lcd_panel_model.sv
// Passive segment glass: counts refreshed frames and keeps the shown image
`timescale 1ns/1ps
module lcd_panel_model
   import lcd_cfg_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Drive from the block
   input wire lcd_cfg_pkg::frame_cfg_type frame_cfg,
   input wire logic frame_start,
   input wire logic [8*lcd_cfg_pkg::SEGMENT_BYTES-1:0] display_data,
   // Observation
   output int frames,
   output logic [8*lcd_cfg_pkg::SEGMENT_BYTES-1:0] shown
);
   logic [8*SEGMENT_BYTES-1:0] image_r;

   assign shown = image_r;

   // Glass only shows what arrives while the driver is active
   always_ff @(posedge mclk) begin
      if (reset) begin
         frames <= 0;
         image_r <= '0;
      end else if (frame_start) begin
         frames <= frames + 1;
         if (frame_cfg.active) image_r <= display_data;
      end
   end
endmodule // lcd_panel_model

// >>> tb/lcd_segment_driver_config_test.sv
// Self-checking bench of the segment LCD configuration block
`timescale 1ns/1ps
module lcd_segment_driver_config_test;
   import lcd_cfg_pkg::*;
   logic mclk;
   logic reset;
   sfr_req_type sfr_req;
   logic [7:0] sfr_rdata;
   logic deep_sleep_state;
   frame_cfg_type frame_cfg;
   logic frame_start;
   logic blink_on;
   logic [1:0] blink_source_mode;
   logic [1:0] blink_rate_select;
   logic [7:0] lcd_voltage_config;
   shared_role_type shared_role;
   logic [15:0] pin_select;
   logic [8*SEGMENT_BYTES-1:0] display_data;
   int frames;
   logic [8*SEGMENT_BYTES-1:0] shown;
   int fails;
   int n_checks;
   int cycles;
   logic [7:0] rv;

   lcd_segment_driver_config #(.MEM_BYTES(18), .FAST_CYCLES(4),
      .SLOW_CYCLES(16)) i_lcd_segment_driver_config (.mclk(mclk),
      .reset(reset), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
      .deep_sleep_state(deep_sleep_state), .frame_cfg(frame_cfg),
      .frame_start(frame_start), .blink_on(blink_on),
      .blink_source_mode(blink_source_mode),
      .blink_rate_select(blink_rate_select),
      .lcd_voltage_config(lcd_voltage_config), .shared_role(shared_role),
      .pin_select(pin_select), .display_data(display_data));

   lcd_panel_model i_lcd_panel_model (.mclk(mclk), .reset(reset),
      .frame_cfg(frame_cfg), .frame_start(frame_start),
      .display_data(display_data), .frames(frames), .shown(shown));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Run is a few hundred cycles; the ceiling leaves wide margin
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      sfr_req <= '0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk);
      sfr_req <= '0;
      #1;
      d = sfr_rdata;
   endtask

   // Mirrored outputs follow a write by two cycles
   task automatic settle();
      repeat (2) @(posedge mclk);
      #1;
   endtask

   // Stops in the cycle where frame_start is high
   task automatic wait_frame();
      int n;
      n = 0;
      @(posedge mclk);
      #1;
      while (frame_start !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk("frame_start", 16'h0001, frame_start);
   endtask

   task automatic test_reset();
      logic [7:0] offs [9];
      offs = '{OFF_MAIN_CONFIG, OFF_CLOCK_CONFIG, OFF_PIN_SELECT_LOW,
         OFF_VOLTAGE_CONFIG, OFF_MEMORY_INDEX, OFF_MEMORY_PORT,
         OFF_FRAME_CONTROL, OFF_PIN_SELECT_HIGH, 8'h00};
      foreach (offs[i]) begin
         rd(offs[i], rv);
         chk("reset_read", {8'h00, RESET_VALUE}, rv);
      end
      chk("frame_cfg", 16'h0000, frame_cfg);
      chk("display_zero", 16'h0001, display_data === '0);
      $display("test reset done");
   endtask

   task automatic test_main();
      logic [3:0] role [4];
      logic [1:0] mm;
      logic [7:0] v;
      role = '{4'h0, 4'h5, 4'h6, 4'hA};
      for (int m = 0; m < 4; m++) begin
         mm = m[1:0];
         v = {3'b001, 1'b0, mm[1], mm[0], mm};
         wr(OFF_MAIN_CONFIG, v);
         settle();
         chk("shared_role", {12'h000, role[m]}, shared_role);
         chk("mux", {14'h0000, mm}, frame_cfg.mux);
         chk("slow_clock", {15'h0000, mm[1]}, frame_cfg.slow_clock);
         chk("bias_third", {15'h0000, mm[0]}, frame_cfg.bias_third);
         chk("blink_on", 16'h0001, blink_on);
         chk("active_off", 16'h0000, frame_cfg.active);
         rd(OFF_MAIN_CONFIG, rv);
         chk("main_read", {8'h00, v}, rv);
      end
      $display("test main done");
   endtask

   task automatic test_clock_pins();
      wr(OFF_CLOCK_CONFIG, 8'hE5);
      wr(OFF_PIN_SELECT_LOW, 8'h3C);
      wr(OFF_PIN_SELECT_HIGH, 8'hC3);
      wr(OFF_VOLTAGE_CONFIG, 8'hFF);
      settle();
      chk("blink_mode", 16'h0003, blink_source_mode);
      chk("blink_rate", 16'h0002, blink_rate_select);
      chk("divider", 16'h0005, frame_cfg.divider);
      chk("pin_select", 16'hC33C, pin_select);
      chk("voltage", 16'h007F, lcd_voltage_config);
      rd(OFF_VOLTAGE_CONFIG, rv);
      chk("voltage_read", 16'h007F, rv);
      // Reserved bits of frame control must read back as zero
      wr(OFF_FRAME_CONTROL, 8'hFC);
      settle();
      chk("invert", 16'h0001, frame_cfg.invert);
      rd(OFF_FRAME_CONTROL, rv);
      chk("frame_ctl_read", 16'h0040, rv);
      wr(OFF_FRAME_CONTROL, 8'h00);
      settle();
      chk("invert_off", 16'h0000, frame_cfg.invert);
      $display("test clock_pins done");
   endtask

   task automatic test_memory();
      wr(OFF_MEMORY_INDEX, 8'h03);
      wr(OFF_MEMORY_PORT, 8'h5A);
      rd(OFF_MEMORY_PORT, rv);
      chk("mem3", 16'h005A, rv);
      wr(OFF_MEMORY_INDEX, 8'h11);
      wr(OFF_MEMORY_PORT, 8'hA5);
      rd(OFF_MEMORY_PORT, rv);
      chk("mem17", 16'h00A5, rv);
      wr(OFF_MEMORY_INDEX, 8'h12);
      wr(OFF_MEMORY_PORT, 8'hFF);
      rd(OFF_MEMORY_PORT, rv);
      chk("mem18", 16'h0000, rv);
      $display("test memory done");
   endtask

   task automatic test_frame();
      int f;
      wr(OFF_CLOCK_CONFIG, 8'h03);
      wr(OFF_MAIN_CONFIG, 8'h81);
      wait_frame();
      chk("active_on", 16'h0001, frame_cfg.active);
      chk("byte3", 16'h005A, display_data[31:24]);
      chk("byte17", 16'h00A5, display_data[143:136]);
      rd(OFF_FRAME_CONTROL, rv);
      chk("done_flag", 16'h0002, rv);
      wr(OFF_FRAME_CONTROL, 8'h01);
      wr(OFF_MEMORY_INDEX, 8'h03);
      wr(OFF_MEMORY_PORT, 8'h11);
      wait_frame();
      wait_frame();
      chk("hold_byte3", 16'h005A, display_data[31:24]);
      wr(OFF_FRAME_CONTROL, 8'h00);
      wait_frame();
      wait_frame();
      chk("new_byte3", 16'h0011, display_data[31:24]);
      wr(OFF_MAIN_CONFIG, 8'h01);
      settle();
      f = frames;
      repeat (100) @(posedge mclk);
      #1;
      chk("no_frames", 16'h0001, frames == f);
      chk("glass_byte3", 16'h0011, shown[31:24]);
      $display("test frame done");
   endtask

   task automatic test_clear();
      wr(OFF_MAIN_CONFIG, 8'hC1);
      repeat (3) @(posedge mclk);
      rd(OFF_MAIN_CONFIG, rv);
      chk("clear_bit", 16'h0081, rv);
      wr(OFF_MEMORY_INDEX, 8'h03);
      rd(OFF_MEMORY_PORT, rv);
      chk("cleared_mem", 16'h0000, rv);
      wait_frame();
      chk("cleared_disp", 16'h0001, display_data === '0);
      $display("test clear done");
   endtask

   // Voltage reference taken as already on before sleep
   task automatic test_sleep();
      @(posedge mclk);
      deep_sleep_state <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      chk("sleep_on", 16'h0001, frame_cfg.active);
      wr(OFF_MAIN_CONFIG, 8'h91);
      repeat (4) @(posedge mclk);
      #1;
      chk("sleep_off", 16'h0000, frame_cfg.active);
      @(posedge mclk);
      deep_sleep_state <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      chk("awake_on", 16'h0001, frame_cfg.active);
      $display("test sleep done");
   endtask

   initial begin
      reset = 1'b1;
      sfr_req = '0;
      deep_sleep_state = 1'b0;
      fails = 0;
      n_checks = 0;
      cycles = 0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      test_reset();
      test_main();
      test_clock_pins();
      test_memory();
      test_frame();
      test_clear();
      test_sleep();
      results();
   end
endmodule // lcd_segment_driver_config_test
